// >>> sbc_cfg.svh
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH
`define SBC_CFG_ADDR 8'hc1
`define SBC_CFG_RESET 8'h00
`define SBC_BIT_ENABLE 7
`define SBC_BIT_INHIBIT 6
`define SBC_BIT_BUSY 5
`define SBC_BIT_EXTHOLD 4
`define SBC_BIT_TOE 3
`define SBC_BIT_FTE 2
`define SBC_CS_HI 1
`define SBC_CS_LO 0
`define SBC_FREE_PERIODS 10
`endif

// >>> sbc_pkg.sv
package sbc_pkg;
    typedef enum logic [1:0] {
        SBC_SRC_T0 = 2'h0,
        SBC_SRC_T5 = 2'h1,
        SBC_SRC_T2H = 2'h2,
        SBC_SRC_T2L = 2'h3
    } sbc_src_t;
    typedef enum {
        SBC_IDLE,
        SBC_BUSY
    } sbc_state_t;
endpackage : sbc_pkg

// >>> sbc_free_if.sv
interface sbc_free_if;
    logic tick;
    logic lines_high;
    logic run;
    logic expired;
    modport ctl (output tick, output lines_high, output run, input expired);
    modport cnt (input tick, input lines_high, input run, output expired);
endinterface : sbc_free_if

// >>> sbc_free_timer.sv
`include "sbc_cfg.svh"
module sbc_free_timer
    import sbc_pkg::*;
#(
    parameter int PERIODS = `SBC_FREE_PERIODS
)
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    sbc_free_if.cnt bus
);
    localparam int CW = $clog2(PERIODS + 2);
    logic [CW-1:0] count;

    // Counts source ticks with both lines high; fires on the eleventh one.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            count <= '0;
        end
        else if (clk_en_in)
        begin
            if (!bus.run || !bus.lines_high)
            begin
                count <= '0;
            end
            else if (bus.tick && count <= CW'(PERIODS))
            begin
                count <= count + CW'(1);
            end
        end
    end

    assign bus.expired = bus.run && bus.lines_high && bus.tick && (count == CW'(PERIODS));
endmodule : sbc_free_timer

// >>> sbc_config.sv
// Behaviour
// - Enable bit makes the port sample and monitor its lines; cleared, it ignores bus.
// - Slave inhibit suppresses slave event interrupts; master interrupts pass unchanged.
// - Busy flag sets during a transfer; clears on STOP or bus-free timeout.
// - Timing extension bit selects normal or extended SDA setup and hold.
// - SCL-low timeout holds timer in reload while clock high, counts while low.
// - In split mode only the timer high byte is held in reload.
// - Free timeout: bus free after both lines high over ten source periods.
// - Clock source field selects timer 0, timer 5, timer 2 high or low overflow.
//
// Design decision made here: strobed register access.
`include "sbc_cfg.svh"
module sbc_config
    import sbc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic port_data_line_in,
    input wire logic port_clock_line_in,
    input wire logic start_seen_in,
    input wire logic stop_seen_in,
    input wire logic slave_event_in,
    input wire logic master_event_in,
    input wire logic timer_split_mode_in,
    input wire logic timer0_ovf_in,
    input wire logic timer5_ovf_in,
    input wire logic timer2h_ovf_in,
    input wire logic timer2l_ovf_in,
    output logic port_active_out,
    output logic port_data_line_out,
    output logic port_clock_line_out,
    output logic irq_request_out,
    output logic sda_timing_extension_out,
    output logic timer_reload_high_out,
    output logic timer_reload_low_out,
    output logic bit_rate_tick_out,
    output logic bus_free_out
);
    logic port_enable_bit;
    logic slave_event_inhibit;
    logic sda_timing_extension;
    logic scl_low_timeout_enable;
    logic bus_free_timeout_enable;
    sbc_src_t bit_rate_source_select;
    sbc_state_t state;
    logic sda_q;
    logic scl_q;
    logic next_tick;
    logic cfg_wr;
    logic [7:0] cfg_value;
    sbc_free_if fif ();

    assign cfg_wr = reg_wr_in && (reg_addr_in == `SBC_CFG_ADDR);

    // The busy bit lane of the write data is discarded.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            port_enable_bit <= 1'b0;
            slave_event_inhibit <= 1'b0;
            sda_timing_extension <= 1'b0;
            scl_low_timeout_enable <= 1'b0;
            bus_free_timeout_enable <= 1'b0;
            bit_rate_source_select <= SBC_SRC_T0;
        end
        else if (clk_en_in && cfg_wr)
        begin
            port_enable_bit <= reg_wdata_in[`SBC_BIT_ENABLE];
            slave_event_inhibit <= reg_wdata_in[`SBC_BIT_INHIBIT];
            sda_timing_extension <= reg_wdata_in[`SBC_BIT_EXTHOLD];
            scl_low_timeout_enable <= reg_wdata_in[`SBC_BIT_TOE];
            bus_free_timeout_enable <= reg_wdata_in[`SBC_BIT_FTE];
            bit_rate_source_select <= sbc_src_t'(reg_wdata_in[`SBC_CS_HI:`SBC_CS_LO]);
        end
    end

    always_comb
    begin
        cfg_value = 8'h00;
        cfg_value[`SBC_BIT_ENABLE] = port_enable_bit;
        cfg_value[`SBC_BIT_INHIBIT] = slave_event_inhibit;
        cfg_value[`SBC_BIT_BUSY] = (state == SBC_BUSY);
        cfg_value[`SBC_BIT_EXTHOLD] = sda_timing_extension;
        cfg_value[`SBC_BIT_TOE] = scl_low_timeout_enable;
        cfg_value[`SBC_BIT_FTE] = bus_free_timeout_enable;
        cfg_value[`SBC_CS_HI:`SBC_CS_LO] = bit_rate_source_select;
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else if (clk_en_in)
        begin
            reg_rdata_out <= (reg_rd_in && reg_addr_in == `SBC_CFG_ADDR) ? cfg_value : 8'h00;
        end
    end

    // Line sampling runs only while the port is enabled; idle lines read high.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
        end
        else if (clk_en_in)
        begin
            sda_q <= port_enable_bit ? port_data_line_in : 1'b1;
            scl_q <= port_enable_bit ? port_clock_line_in : 1'b1;
        end
    end

    always_comb
    begin
        unique case (bit_rate_source_select)
            SBC_SRC_T0: next_tick = timer0_ovf_in;
            SBC_SRC_T5: next_tick = timer5_ovf_in;
            SBC_SRC_T2H: next_tick = timer2h_ovf_in;
            SBC_SRC_T2L: next_tick = timer2l_ovf_in;
        endcase
    end

    assign fif.tick = next_tick;
    assign fif.lines_high = sda_q && scl_q;
    assign fif.run = port_enable_bit && bus_free_timeout_enable && (state == SBC_BUSY);

    sbc_free_timer #(.PERIODS(`SBC_FREE_PERIODS)) u_free (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .bus(fif.cnt)
    );

    // Start sets busy over stop or timeout in the same cycle.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state <= SBC_IDLE;
        end
        else if (clk_en_in)
        begin
            if (!port_enable_bit)
            begin
                state <= SBC_IDLE;
            end
            else if (start_seen_in)
            begin
                state <= SBC_BUSY;
            end
            else if (stop_seen_in || fif.expired)
            begin
                state <= SBC_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            port_active_out <= 1'b0;
            port_data_line_out <= 1'b1;
            port_clock_line_out <= 1'b1;
            irq_request_out <= 1'b0;
            sda_timing_extension_out <= 1'b0;
            timer_reload_high_out <= 1'b0;
            timer_reload_low_out <= 1'b0;
            bit_rate_tick_out <= 1'b0;
            bus_free_out <= 1'b1;
        end
        else if (clk_en_in)
        begin
            port_active_out <= port_enable_bit;
            port_data_line_out <= sda_q;
            port_clock_line_out <= scl_q;
            irq_request_out <= port_enable_bit && (master_event_in || (slave_event_in && !slave_event_inhibit));
            sda_timing_extension_out <= sda_timing_extension;
            timer_reload_high_out <= port_enable_bit && scl_low_timeout_enable && port_clock_line_in;
            timer_reload_low_out <= port_enable_bit && scl_low_timeout_enable && port_clock_line_in
                && !timer_split_mode_in;
            bit_rate_tick_out <= port_enable_bit && next_tick;
            bus_free_out <= (state == SBC_IDLE);
        end
    end

    a_busy_clears: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && !start_seen_in && stop_seen_in |=> state == SBC_IDLE)
        else $error("busy did not clear on stop");
    a_busy_sets: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && start_seen_in |=> state == SBC_BUSY)
        else $error("busy did not set on start");
    a_inhibit_slave: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && slave_event_inhibit && !master_event_in |=> !irq_request_out)
        else $error("slave interrupt not inhibited");
    a_master_irq: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && master_event_in |=> irq_request_out)
        else $error("master interrupt lost");
    a_reload_high: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && scl_low_timeout_enable |=> timer_reload_high_out == $past(port_clock_line_in))
        else $error("timer reload does not follow clock line");
    a_split_low: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && timer_split_mode_in |=> !timer_reload_low_out)
        else $error("low byte reloaded in split mode");
    a_disabled_idle: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && !port_enable_bit |=> state == SBC_IDLE && sda_q && scl_q)
        else $error("disabled port still active");
    a_busy_readback: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && reg_rd_in && reg_addr_in == `SBC_CFG_ADDR |=> reg_rdata_out[`SBC_BIT_BUSY] == $past(state == SBC_BUSY))
        else $error("busy readback wrong");
    a_source_t5: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && bit_rate_source_select == SBC_SRC_T5 |=> bit_rate_tick_out == $past(timer5_ovf_in))
        else $error("wrong bit rate source");
    a_ext_timing: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in |=> sda_timing_extension_out == $past(sda_timing_extension))
        else $error("timing extension not applied");
    a_free_clears: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
        clk_en_in && port_enable_bit && !start_seen_in && fif.expired |=> state == SBC_IDLE)
        else $error("busy did not clear on free timeout");
endmodule : sbc_config

// >>> sbc_bus_peer.sv
module sbc_bus_peer
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic hold_clock_low_in,
    input wire logic hold_data_low_in,
    output logic port_clock_line_out,
    output logic port_data_line_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Open-drain lines with pull-ups read high whenever this peer releases them.
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            port_clock_line_out <= 1'b1;
            port_data_line_out <= 1'b1;
        end
        else
        begin
            port_clock_line_out <= !hold_clock_low_in;
            port_data_line_out <= !hold_data_low_in;
        end
    end
endmodule : sbc_bus_peer

// >>> tb.sv
`include "sbc_cfg.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, en = 1, wr = 0, rd = 0, rd_d = 0, scl_low = 0, sda_low = 0, split = 0;
    logic [7:0] addr = 0, wd = 0, rdata, ev = 0;
    logic [31:0] rs = 32'h6eb1a81f;
    logic [7:0] expq[$];
    logic scl, sda, act, dl, cl, irq, ext, rlh, rll, tick, free;
    int fail_count = 0, compares = 0;
    sbc_bus_peer sbc_bus_peer_i (.ref_clk_in(clk), .sys_rst_in(rst), .hold_clock_low_in(scl_low),
        .hold_data_low_in(sda_low), .port_clock_line_out(scl), .port_data_line_out(sda));
    sbc_config sbc_config_i (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .port_data_line_in(sda),
        .port_clock_line_in(scl), .start_seen_in(ev[0]), .stop_seen_in(ev[1]), .slave_event_in(ev[2]),
        .master_event_in(ev[3]), .timer_split_mode_in(split), .timer0_ovf_in(ev[4]), .timer5_ovf_in(ev[5]),
        .timer2h_ovf_in(ev[6]), .timer2l_ovf_in(ev[7]), .port_active_out(act), .port_data_line_out(dl),
        .port_clock_line_out(cl), .irq_request_out(irq), .sda_timing_extension_out(ext),
        .timer_reload_high_out(rlh), .timer_reload_low_out(rll), .bit_rate_tick_out(tick), .bus_free_out(free));
    always #5 clk = !clk;
    function logic [7:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction : xs
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr8
    task rd8(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask : rd8
    task pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
    endtask : pulse
    task chk(input logic g, input logic e);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t output mismatch, got %b", $time, g);
        end
    endtask : chk
    task give_verdict;
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    // Read data stand only in the cycle after the strobe, so they are taken at that cycle's falling edge.
    always @(posedge clk) rd_d <= rd;
    always @(negedge clk)
    begin
        if (rd_d)
        begin
            compares++;
            if (rdata !== expq[0])
            begin
                fail_count++;
                $display("[ERR] %0t read data %h", $time, rdata);
            end
            void'(expq.pop_front());
        end
    end
    initial
    begin
        #20000;
        fail_count++;
        give_verdict;
    end
    initial
    begin
        logic [7:0] d;
        cyc(3);
        rst <= 1'b0;
        rd8(`SBC_CFG_ADDR, 8'h00);
        d = xs();
        wr8(8'hc0, d);
        rd8(8'hc0, 8'h00);
        d = xs();
        wr8(`SBC_CFG_ADDR, d);
        rd8(`SBC_CFG_ADDR, d & 8'hdf);
        wr8(`SBC_CFG_ADDR, 8'hff);
        rd8(`SBC_CFG_ADDR, 8'hdf);
        #1 chk(act, 1'b1);
        chk(ext, 1'b1);
        pulse(2);
        #1 chk(irq, 1'b0);
        pulse(3);
        #1 chk(irq, 1'b1);
        scl_low <= 1'b1;
        cyc(5);
        #1 chk(rlh, 1'b0);
        chk(cl, 1'b0);
        scl_low <= 1'b0;
        split <= 1'b1;
        cyc(5);
        #1 chk(rlh, 1'b1);
        chk(rll, 1'b0);
        split <= 1'b0;
        cyc(3);
        #1 chk(rll, 1'b1);
        for (int s = 0; s < 4; s++)
        begin
            wr8(`SBC_CFG_ADDR, 8'h80 | s[7:0]);
            cyc(1);
            #1 chk(ext, 1'b0);
            for (int j = 0; j < 4; j++)
            begin
                pulse(4 + j);
                #1 chk(tick, j == s);
            end
        end
        wr8(`SBC_CFG_ADDR, 8'h84);
        pulse(0);
        rd8(`SBC_CFG_ADDR, 8'ha4);
        repeat (6) pulse(4);
        sda_low <= 1'b1;
        cyc(5);
        #1 chk(dl, 1'b0);
        sda_low <= 1'b0;
        cyc(4);
        repeat (10) pulse(4);
        cyc(3);
        #1 chk(free, 1'b0);
        pulse(4);
        cyc(3);
        #1 chk(free, 1'b1);
        rd8(`SBC_CFG_ADDR, 8'h84);
        pulse(0);
        pulse(1);
        cyc(2);
        #1 chk(free, 1'b1);
        // Software recovery from a data line held low toggles the enable bit.
        sda_low <= 1'b1;
        wr8(`SBC_CFG_ADDR, 8'h00);
        cyc(4);
        #1 chk(act, 1'b0);
        chk(dl, 1'b1);
        sda_low <= 1'b0;
        wr8(`SBC_CFG_ADDR, 8'h80);
        cyc(2);
        #1 chk(act, 1'b1);
        // With the clock enable low, a write must leave the configuration untouched.
        en <= 1'b0;
        wr8(`SBC_CFG_ADDR, 8'h00);
        en <= 1'b1;
        cyc(2);
        #1 chk(act, 1'b1);
        give_verdict;
    end
endmodule : tb
